// >>> common/chain_regs_pkg.sv
/*
 * Shared constants and types for the chain node register bank: register
 * offsets, reset values, status field positions, checksum settings and the
 * carriers used between the link layer and the register bank.
 * Assumes one system clock and a synchronous active-low reset.
 */
package chain_regs_pkg;

    // widths of the register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int AFIELD_W = 5;

    // fixed register offsets
    localparam logic [ADDR_W-1:0] OFS_ID = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ADDR = 8'h01;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h02;
    localparam logic [ADDR_W-1:0] OFS_AUX1 = 8'h2d;
    localparam logic [ADDR_W-1:0] OFS_AUX2 = 8'h2e;
    localparam logic [ADDR_W-1:0] OFS_TOTAL = 8'h2f;
    localparam logic [ADDR_W-1:0] OFS_DIAGNOSTIC_RESULT = 8'h50;

    // plain read/write table: thresholds, diagnostic setup, alu check data
    localparam int NUM_RW = 16;
    localparam logic [ADDR_W-1:0] RW_OFS [NUM_RW] = '{
        8'h40, 8'h42, 8'h44, 8'h46, 8'h48, 8'h49, 8'h4a, 8'h4b,
        8'h4c, 8'h4d, 8'h51, 8'h52, 8'h57, 8'h58, 8'h59, 8'h5a};
    localparam logic [DATA_W-1:0] RW_RST [NUM_RW] = '{
        16'hfffc, 16'hfffc, 16'h0000, 16'h0000, 16'hfffc, 16'h0000, 16'hfff0, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    localparam int RW_IDX_MISMATCH = 4;

    // reset values of the special registers
    localparam logic [DATA_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [DATA_W-1:0] STATUS_RST = 16'h8000;

    // status bit positions
    localparam int ST_POR = 15;
    localparam int ST_OV = 14;
    localparam int ST_UV = 13;
    localparam int ST_SHDN_LATCH = 12;
    localparam int ST_SHDN_LIVE = 11;
    localparam int ST_MISMATCH = 10;
    localparam int ST_COLD = 9;
    localparam int ST_HOT = 8;
    localparam int ST_PEC = 7;
    localparam int ST_MAN = 4;
    localparam int ST_PAR = 2;
    localparam int ST_FAULT2 = 1;
    localparam int ST_FAULT1 = 0;

    // address register field positions
    localparam int FA_LSB = 8;
    localparam int DA_LSB = 0;

    // packet checksum: lsb-first crc-8, x^8+x^6+x^3+x^2+1
    localparam logic [7:0] CRC_POLY = 8'hb2;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // command kinds handed over by the link layer
    typedef enum logic [1:0] {
        CMD_NONE = 2'b00,
        CMD_WRITE = 2'b01,
        CMD_ENUM = 2'b10
    } cmd_kind_e;

    typedef struct packed {
        cmd_kind_e kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [7:0] pec;
    } cmd_s;

    typedef struct packed {
        logic [15:0] cell_over;
        logic [15:0] cell_under;
        logic [15:0] fault1;
        logic [15:0] fault2;
        logic aux0_over;
        logic aux1_over;
        logic aux0_under;
        logic aux1_under;
    } alert_s;

endpackage

// >>> verilog/packet_crc8.sv
/*
 * Running packet checksum over the command bytes of one packet.
 * Assumes the link layer pulses start_in at the first byte of a packet and
 * feeds neither the checksum byte nor the alive-counter byte.
 */
`timescale 1ns/1ps

module packet_crc8
    import chain_regs_pkg::*;
(
    input wire logic sys_clk_in, // system clock
    input wire logic resetn_in, // synchronous reset, active low
    input wire logic start_in, // first byte of a packet
    input wire logic byte_valid_in, // byte strobe
    input wire logic [7:0] byte_in, // packet byte
    output logic [7:0] crc_out // running checksum
);

    logic [7:0] crc_r;
    logic [7:0] seed;

    // one whole byte per cycle, bits taken lsb first
    function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    // a new packet restarts from the initial value, even on its first byte
    assign seed = start_in ? CRC_INIT : crc_r;

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            crc_r <= CRC_INIT;
        end else if (byte_valid_in) begin
            crc_r <= crc_step(seed, byte_in);
        end else if (start_in) begin
            crc_r <= CRC_INIT;
        end
    end

    assign crc_out = crc_r;

endmodule

// >>> verilog/chain_status_address_regs.sv
/*
 * Register bank of a daisy-chained monitor node: identification, chain
 * address, summary status, result words and the read/write threshold table.
 * Assumes a link layer that decodes frames, feeds command bytes to the
 * checksum engine and then presents one command with its received checksum.
 */
`timescale 1ns/1ps

// Functional notes
// - Power-on reset sets the power-on flag; writing one leaves it alone.
// - Over-voltage summary is OR of all sixteen cell over alerts.
// - Under-voltage summary is OR of all sixteen cell under alerts.
// - Latched shutdown-low flag clears only by writing zero or by reset.
// - Live shutdown-low bit follows the pin during diagnostic with supply valid.
// - Mismatch flag follows max minus min above threshold at each acquisition.
// - Cold summary is OR of over alerts of aux inputs 0 and 1.
// - Hot summary is OR of under alerts of aux inputs 0 and 1.
// - Checksum error sets a sticky flag; only writing zero or reset clears it.
// - Manchester error on lower port sets a sticky flag cleared by zero.
// - Parity error on lower port sets a sticky flag cleared by zero.
// - Fault summary 2 is OR of the second fault-mode word.
// - Fault summary 1 is OR of the first fault-mode word.
// - Reserved status and address bits read zero and ignore writes.
// - Enumeration stores received address while unlocked and always forwards it plus one.
// - Own address changes only by enumeration while unlock control is one.
// - First and own address fields feed broadcast read check handling.
// - Identification is read-only: model number high, die version low.
// - Commands with a wrong checksum byte are never executed.
// - Checksum is lsb-first crc-8 from zero, poly x^8+x^6+x^3+x^2+1.
module chain_status_address_regs
    import chain_regs_pkg::*;
#(
    parameter logic [11:0] MODEL_NUMBER = 12'h5a1, // arbitrary value
    parameter logic [3:0] DIE_VERSION = 4'h9 // arbitrary value
) (
    input wire logic sys_clk_in, // system clock, 20 MHz
    input wire logic resetn_in, // synchronous reset, active low
    input wire logic pkt_start_in, // first byte of a packet
    input wire logic pkt_byte_valid_in, // packet byte strobe
    input wire logic [7:0] pkt_byte_in, // packet byte
    input wire logic cmd_valid_in, // command ready to execute
    input wire cmd_s cmd_in, // kind, address, data, received checksum
    input wire logic link_pec_err_in, // checksum error seen by the link
    input wire logic manchester_err_in, // manchester error, lower port
    input wire logic parity_err_in, // parity error, lower port
    input wire logic addr_unlock_in, // address unlock control
    input wire logic shutdown_pin_in, // shutdown pin level, asynchronous
    input wire logic shdn_diagnostic_result_active_in, // shutdown diagnostic running
    input wire logic vaa_above_por_in, // analog supply above falling level
    input wire logic acq_done_in, // acquisition finished
    input wire logic [DATA_W-1:0] cell_max_in, // highest cell reading
    input wire logic [DATA_W-1:0] cell_min_in, // lowest cell reading
    input wire alert_s alerts_in, // alert and fault words
    input wire logic [DATA_W-1:0] aux1_result_in, // aux input 1 result
    input wire logic [DATA_W-1:0] aux2_result_in, // aux input 2 result
    input wire logic [DATA_W-1:0] total_result_in, // sum of cells
    input wire logic [DATA_W-1:0] diagnostic_result_result_in, // diagnostic result
    input wire logic rd_valid_in, // read request
    input wire logic [ADDR_W-1:0] rd_addr_in, // read address
    output logic [DATA_W-1:0] rd_data_out, // read data
    output logic rd_ack_out, // read data valid, one cycle
    output logic cmd_exec_out, // command executed, one cycle
    output logic pec_fail_out, // command dropped, one cycle
    output logic enum_fwd_valid_out, // forward enumeration, one cycle
    output logic [AFIELD_W-1:0] enum_fwd_addr_out, // address for next device
    output logic [AFIELD_W-1:0] first_address_out, // first address field
    output logic [AFIELD_W-1:0] own_address_out, // own address field
    output logic [NUM_RW-1:0][DATA_W-1:0] threshold_out // read/write table
);

    logic [7:0] crc_val;
    logic pec_ok;
    logic pec_bad;
    logic exec_write;
    logic exec_enum;
    logic status_wr;
    logic addr_wr;
    logic [AFIELD_W-1:0] fa_r;
    logic [AFIELD_W-1:0] da_r;
    logic [AFIELD_W-1:0] fwd_addr_r;
    logic fwd_valid_r;
    logic exec_r;
    logic fail_r;
    logic por_r;
    logic por_nxt;
    logic pec_flag_r;
    logic pec_flag_nxt;
    logic man_flag_r;
    logic man_flag_nxt;
    logic par_flag_r;
    logic par_flag_nxt;
    logic shdn_latch_r;
    logic shdn_latch_nxt;
    logic shdn_live_r;
    logic mismatch_r;
    logic mismatch_hit;
    logic [DATA_W-1:0] cell_spread;
    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic pin_lvl_r;
    logic shdn_sample;
    logic [NUM_RW-1:0][DATA_W-1:0] rw_r;
    logic [NUM_RW-1:0][DATA_W-1:0] rw_rd;
    logic [DATA_W-1:0] rw_or;
    logic [DATA_W-1:0] id_word;
    logic [DATA_W-1:0] addr_word;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] rd_data_r;
    logic rd_ack_r;
    logic ov_sum;
    logic uv_sum;
    logic cold_sum;
    logic hot_sum;
    logic f1_sum;
    logic f2_sum;

    // checksum over the command bytes of the current packet
    packet_crc8 u_crc (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .start_in(pkt_start_in),
        .byte_valid_in(pkt_byte_valid_in),
        .byte_in(pkt_byte_in),
        .crc_out(crc_val)
    );

    // command gating: nothing executes unless the checksums match
    assign pec_ok = (crc_val == cmd_in.pec);
    assign pec_bad = cmd_valid_in && (cmd_in.kind != CMD_NONE) && !pec_ok;
    assign exec_write = cmd_valid_in && (cmd_in.kind == CMD_WRITE) && pec_ok;
    assign exec_enum = cmd_valid_in && (cmd_in.kind == CMD_ENUM) && pec_ok;
    assign status_wr = exec_write && (cmd_in.addr == OFS_STATUS);
    assign addr_wr = exec_write && (cmd_in.addr == OFS_ADDR);

    // summary flags are pure functions of their sources, so writes cannot touch them
    assign ov_sum = |alerts_in.cell_over;
    assign uv_sum = |alerts_in.cell_under;
    assign cold_sum = alerts_in.aux0_over | alerts_in.aux1_over;
    assign hot_sum = alerts_in.aux0_under | alerts_in.aux1_under;
    assign f2_sum = |alerts_in.fault2;
    assign f1_sum = |alerts_in.fault1;

    // sticky flags: a new event wins over a clear in the same cycle
    assign por_nxt = por_r && !(status_wr && !cmd_in.data[ST_POR]);
    assign pec_flag_nxt = pec_bad || link_pec_err_in || (pec_flag_r && !(status_wr && !cmd_in.data[ST_PEC]));
    assign man_flag_nxt = manchester_err_in || (man_flag_r && !(status_wr && !cmd_in.data[ST_MAN]));
    assign par_flag_nxt = parity_err_in || (par_flag_r && !(status_wr && !cmd_in.data[ST_PAR]));
    assign shdn_latch_nxt = shdn_sample || (shdn_latch_r && !(status_wr && !cmd_in.data[ST_SHDN_LATCH]));

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            por_r <= STATUS_RST[ST_POR];
            pec_flag_r <= STATUS_RST[ST_PEC];
            man_flag_r <= STATUS_RST[ST_MAN];
            par_flag_r <= STATUS_RST[ST_PAR];
            shdn_latch_r <= STATUS_RST[ST_SHDN_LATCH];
        end else begin
            por_r <= por_nxt;
            pec_flag_r <= pec_flag_nxt;
            man_flag_r <= man_flag_nxt;
            par_flag_r <= par_flag_nxt;
            shdn_latch_r <= shdn_latch_nxt;
        end
    end

    // shutdown pin crosses in through three stages; a change counts once stages two and three agree
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            sync3_r <= 1'b1;
            pin_lvl_r <= 1'b1;
        end else begin
            sync1_r <= shutdown_pin_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            pin_lvl_r <= (sync2_r == sync3_r) ? sync3_r : pin_lvl_r;
        end
    end

    // the pin is only meaningful while the diagnostic runs on a valid supply
    assign shdn_sample = shdn_diagnostic_result_active_in && vaa_above_por_in && !pin_lvl_r;

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            shdn_live_r <= STATUS_RST[ST_SHDN_LIVE];
        end else if (shdn_diagnostic_result_active_in && vaa_above_por_in) begin
            shdn_live_r <= !pin_lvl_r;
        end
    end

    // mismatch is re-evaluated at every acquisition, so it clears itself; a negative spread counts as none
    assign cell_spread = (cell_max_in > cell_min_in) ? (cell_max_in - cell_min_in) : '0;
    assign mismatch_hit = cell_spread > rw_r[RW_IDX_MISMATCH];

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            mismatch_r <= STATUS_RST[ST_MISMATCH];
        end else if (acq_done_in) begin
            mismatch_r <= mismatch_hit;
        end
    end

    // address fields: first address by broadcast write, own address only by unlocked enumeration
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            fa_r <= ADDR_RST[FA_LSB +: AFIELD_W];
            da_r <= ADDR_RST[DA_LSB +: AFIELD_W];
        end else begin
            if (addr_wr) begin
                fa_r <= cmd_in.data[FA_LSB +: AFIELD_W];
            end
            if (exec_enum && addr_unlock_in) begin
                da_r <= cmd_in.data[DA_LSB +: AFIELD_W];
            end
        end
    end

    // enumeration passes on the received address plus one; the host keeps it within five bits
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            fwd_valid_r <= 1'b0;
            fwd_addr_r <= '0;
            exec_r <= 1'b0;
            fail_r <= 1'b0;
        end else begin
            fwd_valid_r <= exec_enum;
            fwd_addr_r <= exec_enum ? (cmd_in.data[DA_LSB +: AFIELD_W] + 5'h01) : fwd_addr_r;
            exec_r <= exec_write || exec_enum;
            fail_r <= pec_bad;
        end
    end

    // read/write table, one register per entry
    for (genvar g = 0; g < NUM_RW; g++) begin : g_rw
        always_ff @(posedge sys_clk_in) begin
            if (!resetn_in) begin
                rw_r[g] <= RW_RST[g];
            end else if (exec_write && (cmd_in.addr == RW_OFS[g])) begin
                rw_r[g] <= cmd_in.data;
            end
        end
        assign rw_rd[g] = (rd_addr_in == RW_OFS[g]) ? rw_r[g] : '0;
    end

    // at most one table entry matches, so an or-tree serves as the selector
    always_comb begin
        rw_or = '0;
        for (int i = 0; i < NUM_RW; i++) begin
            rw_or = rw_or | rw_rd[i];
        end
    end

    // read words; reserved bits are constant zero
    assign id_word = {MODEL_NUMBER, DIE_VERSION};
    assign addr_word = {3'h0, fa_r, 3'h0, da_r};
    assign status_word = {por_r, ov_sum, uv_sum, shdn_latch_r, shdn_live_r, mismatch_r, cold_sum, hot_sum,
                          pec_flag_r, 2'h0, man_flag_r, 1'h0, par_flag_r, f2_sum, f1_sum};

    // read selection; unmapped addresses read zero
    assign rd_word = (rd_addr_in == OFS_ID) ? id_word :
                     (rd_addr_in == OFS_ADDR) ? addr_word :
                     (rd_addr_in == OFS_STATUS) ? status_word :
                     (rd_addr_in == OFS_AUX1) ? aux1_result_in :
                     (rd_addr_in == OFS_AUX2) ? aux2_result_in :
                     (rd_addr_in == OFS_TOTAL) ? total_result_in :
                     (rd_addr_in == OFS_DIAGNOSTIC_RESULT) ? diagnostic_result_result_in : rw_or;

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            rd_data_r <= '0;
            rd_ack_r <= 1'b0;
        end else begin
            rd_data_r <= rd_valid_in ? rd_word : rd_data_r;
            rd_ack_r <= rd_valid_in;
        end
    end

    // outputs
    assign rd_data_out = rd_data_r;
    assign rd_ack_out = rd_ack_r;
    assign cmd_exec_out = exec_r;
    assign pec_fail_out = fail_r;
    assign enum_fwd_valid_out = fwd_valid_r;
    assign enum_fwd_addr_out = fwd_addr_r;
    assign first_address_out = fa_r;
    assign own_address_out = da_r;
    assign threshold_out = rw_r;

    // checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);

    sequence good_enum_s;
        cmd_valid_in && (cmd_in.kind == CMD_ENUM) && (crc_val == cmd_in.pec);
    endsequence

    sequence status_read_s;
        rd_valid_in && (rd_addr_in == OFS_STATUS);
    endsequence

    AST_POR_AFTER_RESET: assert property (!$past(resetn_in) |-> status_word[ST_POR])
        else $error("power-on flag not set after reset");
    AST_POR_WRITE_ONE: assert property (por_r && status_wr && cmd_in.data[ST_POR] |=> por_r)
        else $error("writing one changed the power-on flag");
    AST_OV_READ: assert property (status_read_s |=> rd_data_out[ST_OV] == $past(|alerts_in.cell_over))
        else $error("over-voltage summary read wrong");
    AST_UV_READ: assert property (status_read_s |=> rd_data_out[ST_UV] == $past(|alerts_in.cell_under))
        else $error("under-voltage summary read wrong");
    AST_SHDN_HOLD: assert property (shdn_latch_r && !(status_wr && !cmd_in.data[ST_SHDN_LATCH]) |=> shdn_latch_r)
        else $error("latched shutdown flag lost");
    AST_SHDN_PIN: assert property (shdn_diagnostic_result_active_in && vaa_above_por_in && !shutdown_pin_in [*4]
                                   ##1 shdn_diagnostic_result_active_in && vaa_above_por_in |=> shdn_live_r)
        else $error("live shutdown bit missed a low pin");
    AST_MISMATCH: assert property (acq_done_in |=> mismatch_r == $past(mismatch_hit))
        else $error("mismatch flag not updated at acquisition");
    AST_TEMP_READ: assert property (status_read_s |=> rd_data_out[ST_COLD] == $past(cold_sum)
                                    && rd_data_out[ST_HOT] == $past(hot_sum))
        else $error("temperature summary read wrong");
    AST_PEC_STICKY: assert property (pec_bad |=> pec_flag_r ##1 pec_flag_r || $past(status_wr))
        else $error("checksum flag not sticky");
    AST_LINK_ERR: assert property (manchester_err_in || parity_err_in
                                   |=> (man_flag_r || !$past(manchester_err_in)) && (par_flag_r || !$past(parity_err_in)))
        else $error("link error flag not set");
    AST_FAULT_READ: assert property (status_read_s |=> rd_data_out[1:0] == $past({f2_sum, f1_sum}))
        else $error("fault summary read wrong");
    AST_RESERVED: assert property (rd_valid_in |=> (rd_data_out[6:5] == 2'h0 && rd_data_out[3] == 1'b0)
                                   || $past(rd_addr_in) != OFS_STATUS)
        else $error("reserved status bits not zero");
    AST_ENUM_STORE: assert property (good_enum_s ##0 addr_unlock_in |=> own_address_out == $past(cmd_in.data[4:0])
                                     && enum_fwd_valid_out && enum_fwd_addr_out == own_address_out + 5'h01)
        else $error("enumeration address not stored or forwarded");
    AST_ENUM_LOCKED: assert property (!(exec_enum && addr_unlock_in) |=> $stable(own_address_out))
        else $error("own address changed without unlocked enumeration");
    AST_ID_READ: assert property (rd_valid_in && rd_addr_in == OFS_ID |=> rd_data_out == {MODEL_NUMBER, DIE_VERSION})
        else $error("identification read wrong");
    AST_PEC_BLOCK: assert property (pec_bad |=> !cmd_exec_out && pec_fail_out && $stable(threshold_out))
        else $error("command with bad checksum executed");

endmodule

// >>> sim/link_host_model.sv
/*
 * Host and link-layer stand-in: sends command bytes with a running
 * checksum, then hands over one command. Assumes the bench calls send.
 */
`timescale 1ns/1ps

module link_host_model
    import chain_regs_pkg::*;
(
    input wire logic sys_clk_in, // system clock
    output logic pkt_start_out, // first packet byte
    output logic pkt_byte_valid_out, // byte strobe
    output logic [7:0] pkt_byte_out, // packet byte
    output logic cmd_valid_out, // command strobe
    output cmd_s cmd_out // command carrier
);
    // one byte of the lsb-first checksum, reflected polynomial
    function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ 8'hb2) : (r >> 1);
        end
        return r;
    endfunction

    initial begin
        pkt_start_out = 1'b0;
        pkt_byte_valid_out = 1'b0;
        pkt_byte_out = 8'h00;
        cmd_valid_out = 1'b0;
        cmd_out = '0;
    end

    // bad flips the checksum byte so the device must drop the command
    task automatic send(input cmd_kind_e k, input logic [7:0] a, input logic [15:0] d, input logic bad);
        logic [7:0] b [4];
        logic [7:0] c;
        b = '{{6'h00, k}, a, d[7:0], d[15:8]};
        c = 8'h00;
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk_in);
            pkt_start_out = (i == 0);
            pkt_byte_valid_out = 1'b1;
            pkt_byte_out = b[i];
            c = crc_byte(c, b[i]);
        end
        @(negedge sys_clk_in);
        pkt_start_out = 1'b0;
        pkt_byte_valid_out = 1'b0;
        pkt_byte_out = ~b[3]; // released line shows no stale byte
        cmd_valid_out = 1'b1;
        cmd_out = '{k, a, d, bad ? ~c : c};
        @(negedge sys_clk_in);
        cmd_valid_out = 1'b0;
        cmd_out.data = ~d;
    endtask
endmodule

// >>> sim/test_chain_status_address_regs.sv
/*
 * Self-checking bench for the chain node register bank.
 * Assumes the link model drives commands; the bench drives all else.
 */
`timescale 1ns/1ps

module test_chain_status_address_regs;
    import chain_regs_pkg::*;
    localparam logic [11:0] MOD = 12'h3c7; // arbitrary value
    localparam logic [3:0] VER = 4'h2; // arbitrary value
    localparam logic [15:0] SM [7] = '{16'h4000, 16'h2000, 16'h0200, 16'h0100, 16'h0002, 16'h0001, 16'h0300};
    logic sys_clk_in = 0, resetn_in = 0, mc = 0, pe = 0, le = 0, unl = 0, pin = 1, dg = 0, vaa = 0, acq = 0, rv = 0;
    logic [7:0] ra = 8'h00, pb;
    logic [15:0] mx = 16'h0, mn = 16'h0, rs = 16'h1234, rdat;
    logic ps, pv, cv, ak, ex, pf, fv;
    logic [4:0] fa, fst, own;
    logic [NUM_RW-1:0][15:0] thr;
    alert_s al = '0;
    cmd_s cm;
    int num_errors = 0, tests_run = 0;

    always #25 sys_clk_in = ~sys_clk_in;

    link_host_model i_host (.sys_clk_in(sys_clk_in), .pkt_start_out(ps), .pkt_byte_valid_out(pv),
        .pkt_byte_out(pb), .cmd_valid_out(cv), .cmd_out(cm));

    chain_status_address_regs #(.MODEL_NUMBER(MOD), .DIE_VERSION(VER)) i_dut (.sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in), .pkt_start_in(ps), .pkt_byte_valid_in(pv), .pkt_byte_in(pb), .cmd_valid_in(cv),
        .cmd_in(cm), .link_pec_err_in(le), .manchester_err_in(mc), .parity_err_in(pe), .addr_unlock_in(unl),
        .shutdown_pin_in(pin), .shdn_diagnostic_result_active_in(dg), .vaa_above_por_in(vaa), .acq_done_in(acq),
        .cell_max_in(mx), .cell_min_in(mn), .alerts_in(al), .aux1_result_in(rs), .aux2_result_in(~rs),
        .total_result_in({rs[7:0], rs[15:8]}), .diagnostic_result_result_in(rs ^ 16'h00ff), .rd_valid_in(rv),
        .rd_addr_in(ra), .rd_data_out(rdat), .rd_ack_out(ak), .cmd_exec_out(ex), .pec_fail_out(pf),
        .enum_fwd_valid_out(fv), .enum_fwd_addr_out(fa), .first_address_out(fst), .own_address_out(own),
        .threshold_out(thr));

    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    // one read request, answer one cycle later
    task automatic rc(input logic [7:0] a, input logic [15:0] e, input string n);
        @(negedge sys_clk_in);
        rv = 1;
        ra = a;
        @(negedge sys_clk_in);
        rv = 0;
        ra = ~a;
        chk("read ack", {15'h0, ak}, 16'h0001);
        chk(n, rdat, e);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_host.send(CMD_WRITE, a, d, 1'b0);
        chk("exec", {15'h0, ex}, 16'h0001);
    endtask

    task automatic t_reset;
        rc(OFS_ID, {MOD, VER}, "id");
        rc(OFS_STATUS, 16'h8000, "status");
        rc(OFS_ADDR, 16'h0000, "address");
        rc(8'h03, 16'h0000, "unmapped");
        rc(OFS_AUX1, rs, "aux1");
        rc(OFS_AUX2, ~rs, "aux2");
        rc(OFS_TOTAL, {rs[7:0], rs[15:8]}, "total");
        rc(OFS_DIAGNOSTIC_RESULT, rs ^ 16'h00ff, "diagnostic_result");
        for (int i = 0; i < NUM_RW; i++) rc(RW_OFS[i], RW_RST[i], "table");
        wr(OFS_ID, 16'h0000);
        rc(OFS_ID, {MOD, VER}, "id kept");
        wr(OFS_STATUS, 16'hffff);
        rc(OFS_STATUS, 16'h8000, "por kept");
        wr(OFS_STATUS, 16'h0000);
        rc(OFS_STATUS, 16'h0000, "por clear");
    endtask

    task automatic t_errs;
        @(negedge sys_clk_in);
        {mc, pe, le} = 3'b111;
        @(negedge sys_clk_in);
        {mc, pe, le} = 3'b000;
        rc(OFS_STATUS, 16'h0094, "sticky");
        wr(OFS_STATUS, 16'hffff);
        rc(OFS_STATUS, 16'h0094, "sticky kept");
        wr(OFS_STATUS, 16'h0000);
        rc(OFS_STATUS, 16'h0000, "sticky clear");
    endtask

    // one source per summary bit alone, then aux0 over with aux1 under, so a swapped summary bit shows
    task automatic t_sum;
        for (int i = 0; i < 7; i++) begin
            al = '0;
            case (i)
                0: al.cell_over[15] = 1'b1;
                1: al.cell_under[0] = 1'b1;
                2: al.aux1_over = 1'b1;
                3: al.aux0_under = 1'b1;
                4: al.fault2[15] = 1'b1;
                5: al.fault1[0] = 1'b1;
                default: {al.aux0_over, al.aux1_under} = 2'b11;
            endcase
            rc(OFS_STATUS, SM[i], "summary");
        end
        al = '1;
        wr(OFS_STATUS, 16'h0000);
        rc(OFS_STATUS, 16'h6303, "summary kept");
        al = '0;
    endtask

    task automatic acqp(input logic [15:0] h, input logic [15:0] l);
        @(negedge sys_clk_in);
        {mx, mn, acq} = {h, l, 1'b1};
        @(negedge sys_clk_in);
        acq = 0;
    endtask

    task automatic t_msm;
        wr(8'h48, 16'h0010);
        chk("mismatch thr", thr[RW_IDX_MISMATCH], 16'h0010);
        acqp(16'h0131, 16'h0120);
        rc(OFS_STATUS, 16'h0400, "mismatch set");
        acqp(16'h0130, 16'h0120);
        rc(OFS_STATUS, 16'h0000, "mismatch clear");
    endtask

    task automatic t_pec;
        i_host.send(CMD_WRITE, 8'h40, 16'h1234, 1'b1);
        chk("drop", {14'h0, pf, ex}, 16'h0002);
        rc(8'h40, 16'hfffc, "not written");
        rc(OFS_STATUS, 16'h0080, "pec flag");
        wr(OFS_STATUS, 16'h0000);
    endtask

    task automatic t_enum;
        i_host.send(CMD_ENUM, 8'h00, 16'h0005, 1'b0);
        chk("fwd", {10'h0, fv, fa}, 16'h0026);
        chk("own locked", {11'h0, own}, 16'h0000);
        unl = 1;
        i_host.send(CMD_ENUM, 8'h00, 16'h001e, 1'b0);
        chk("fwd top", {10'h0, fv, fa}, 16'h003f);
        wr(OFS_ADDR, 16'hffff);
        rc(OFS_ADDR, 16'h1f1e, "address");
        chk("fields", {6'h0, fst, own}, 16'h03fe);
    endtask

    task automatic t_shdn;
        {dg, vaa, pin} = 3'b110;
        repeat (8) @(negedge sys_clk_in);
        rc(OFS_STATUS, 16'h1800, "shdn low");
        pin = 1;
        repeat (8) @(negedge sys_clk_in);
        rc(OFS_STATUS, 16'h1000, "shdn latched");
        wr(OFS_STATUS, 16'h0000);
        rc(OFS_STATUS, 16'h0000, "shdn clear");
        resetn_in = 0;
        repeat (2) @(negedge sys_clk_in);
        resetn_in = 1;
        rc(OFS_STATUS, 16'h8000, "por again");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // the whole run needs about 200 cycles
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(negedge sys_clk_in);
        resetn_in = 1;
        t_reset();
        t_errs();
        t_sum();
        t_msm();
        t_pec();
        t_enum();
        t_shdn();
        tally_and_finish();
    end
endmodule
